// ===== hw/regulator_pkg.sv
// constants, register map and types for the charge switch regulator
package regulator_pkg;

	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned PWM_RATE_HZ = 58;
	localparam int unsigned PWM_SLOTS = 256;
	// period rounds down slightly, so the rate sits a hair above 58 Hz
	localparam int unsigned PWM_SLOT_CYCLES = CLK_HZ / (PWM_RATE_HZ * PWM_SLOTS);
	localparam real HOLD_TIME_S = 0.25;
	localparam int unsigned HOLD_CYCLES = int'($ceil(HOLD_TIME_S * real'(CLK_HZ)));
	localparam int unsigned HOLD_W = 27;

	localparam int unsigned VOLT_W = 16;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned DECODE_W = 8;

	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] FUNC_OFS = 8'h04;
	localparam logic [7:0] HYSTERESIS_GAP_OFS = 8'h08;
	localparam logic [7:0] ALARM_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h14;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h18;

	localparam int unsigned PROGRAM_SELECT_LSB = 0;
	localparam int unsigned MODE_LSB = 4;
	localparam int unsigned LOAD_FN_LSB = 0;
	localparam int unsigned RELAY_FN_LSB = 8;
	localparam int unsigned ST_SLOW_BIT = 0;
	localparam int unsigned ST_ALARM_BIT = 1;
	localparam int unsigned ST_MODE_LSB = 2;
	localparam int unsigned ST_DUTY_LSB = 8;

	localparam logic [2:0] USER_PROGRAM = 3'h4;
	localparam logic [1:0] FIXED_PWM_MODE = 2'h1;
	localparam logic [3:0] FN_ALARM = 4'h8;
	localparam logic [3:0] FN_ALARM_INV = 4'h9;
	localparam logic [3:0] FN_SHUNT = 4'hA;
	localparam logic [3:0] FN_SHUNT_INV = 4'hB;

	localparam logic [2:0] PROGRAM_SELECT_RST = 3'h1;
	localparam logic [1:0] MODE_RST = 2'h1;
	localparam logic [3:0] FN_RST = 4'h0;
	localparam logic [15:0] HYSTERESIS_GAP_RST = 16'h0100;
	localparam logic [15:0] ALARM_RST = 16'h0000;
	localparam logic [7:0] DUTY_RST = 8'h80;

	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_ALARM = 0;
	localparam int unsigned IRQ_SWITCH = 1;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_READ = 2'b10
	} bus_state_t;

endpackage

// ===== hw/tick_divider.sv
// divider giving a one-cycle enable pulse every div clock cycles
module tick_divider #(
	parameter int unsigned DIV = 2
) (
	input wire logic clk,
	input wire logic nrst,
	output logic tick
);
	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
	logic [W-1:0] cnt;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt == W'(DIV - 1)) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // tick_divider

// ===== hw/charge_switch_pwm_regulator.sv
// battery regulator: pwm or slow hysteresis switching, alarm outputs, ahb-lite registers
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
module charge_switch_pwm_regulator #(
	parameter int unsigned PWM_SLOT_CYCLES_P = regulator_pkg::PWM_SLOT_CYCLES,
	parameter int unsigned HOLD_CYCLES_P = regulator_pkg::HOLD_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [regulator_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [regulator_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [regulator_pkg::DATA_W-1:0] hrdata,
	input wire logic [regulator_pkg::VOLT_W-1:0] vbat,
	input wire logic [regulator_pkg::VOLT_W-1:0] charge_setpoint,
	output logic solar_switch,
	output logic load_switch,
	output logic relay_switch,
	output logic alarm_led,
	output logic irq
);
	import regulator_pkg::*;

	logic [2:0] program_select;
	logic [1:0] pwm_mode;
	logic [3:0] load_output_function;
	logic [3:0] relay_output_function;
	logic [VOLT_W-1:0] hysteresis_gap;
	logic [VOLT_W-1:0] alarm_level;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	bus_state_t bus_state;
	logic wr_pend;
	logic [DECODE_W-1:0] bus_addr;
	logic addr_ok;
	logic [DATA_W-1:0] rd_mux;
	logic [1:0] eff_mode;
	logic battery_low;
	logic slow_on;
	logic [HOLD_W-1:0] hold_cnt;
	logic hold_done;
	logic [VOLT_W-1:0] turn_on_level;
	logic slow_change;
	logic slot_tick;
	logic [7:0] slot_cnt;
	logic [7:0] duty;
	logic pwm_high;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic next_load;
	logic next_relay;

	// bus slave: writes complete with no wait, reads take one wait state
	assign addr_ok = hsel & htrans[1] & hready;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			bus_state <= BUS_IDLE;
			wr_pend <= 1'b0;
			bus_addr <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= '0;
		end else begin
			wr_pend <= addr_ok & hwrite;
			if (addr_ok) begin
				bus_addr <= haddr[DECODE_W-1:0];
			end
			unique case (bus_state)
				BUS_IDLE: begin
					if (addr_ok && !hwrite) begin
						bus_state <= BUS_READ;
						hreadyout <= 1'b0;
					end
				end
				BUS_READ: begin
					// the wait lets a write in the previous data phase land first
					hrdata <= rd_mux;
					hreadyout <= 1'b1;
					bus_state <= BUS_IDLE;
				end
				default: begin
					bus_state <= BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		rd_mux = '0;
		unique case (bus_addr)
			CTRL_OFS: begin
				rd_mux[PROGRAM_SELECT_LSB +: 3] = program_select;
				rd_mux[MODE_LSB +: 2] = pwm_mode;
			end
			FUNC_OFS: begin
				rd_mux[LOAD_FN_LSB +: 4] = load_output_function;
				rd_mux[RELAY_FN_LSB +: 4] = relay_output_function;
			end
			HYSTERESIS_GAP_OFS: rd_mux[VOLT_W-1:0] = hysteresis_gap;
			ALARM_OFS: rd_mux[VOLT_W-1:0] = alarm_level;
			STATUS_OFS: begin
				rd_mux[ST_SLOW_BIT] = slow_on;
				rd_mux[ST_ALARM_BIT] = alarm_led;
				rd_mux[ST_MODE_LSB +: 2] = eff_mode;
				rd_mux[ST_DUTY_LSB +: 8] = duty;
			end
			IRQ_STATUS_OFS: rd_mux[IRQ_W-1:0] = irq_status;
			IRQ_MASK_OFS: rd_mux[IRQ_W-1:0] = irq_mask;
			default: rd_mux = '0;
		endcase
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			program_select <= PROGRAM_SELECT_RST;
			pwm_mode <= MODE_RST;
			load_output_function <= FN_RST;
			relay_output_function <= FN_RST;
			hysteresis_gap <= HYSTERESIS_GAP_RST;
			alarm_level <= ALARM_RST;
			irq_mask <= '0;
		end else if (wr_pend) begin
			unique case (bus_addr)
				CTRL_OFS: begin
					program_select <= hwdata[PROGRAM_SELECT_LSB +: 3];
					if (hwdata[PROGRAM_SELECT_LSB +: 3] == USER_PROGRAM) begin
						pwm_mode <= hwdata[MODE_LSB +: 2];
					end
				end
				FUNC_OFS: begin
					load_output_function <= hwdata[LOAD_FN_LSB +: 4];
					relay_output_function <= hwdata[RELAY_FN_LSB +: 4];
				end
				HYSTERESIS_GAP_OFS: hysteresis_gap <= hwdata[VOLT_W-1:0];
				ALARM_OFS: alarm_level <= hwdata[VOLT_W-1:0];
				IRQ_MASK_OFS: irq_mask <= hwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	assign eff_mode = (program_select == USER_PROGRAM) ? pwm_mode : FIXED_PWM_MODE;

	assign turn_on_level = (charge_setpoint > hysteresis_gap) ?
		charge_setpoint - hysteresis_gap : '0;
	assign hold_done = hold_cnt >= HOLD_W'(HOLD_CYCLES_P - 1);
	assign slow_change = hold_done &&
		((slow_on && vbat >= charge_setpoint) || (!slow_on && vbat < turn_on_level));

	always_ff @(posedge clk) begin
		if (!nrst) begin
			slow_on <= 1'b0;
		end else if (slow_change) begin
			slow_on <= !slow_on;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			hold_cnt <= '0;
		end else if (slow_change) begin
			hold_cnt <= '0;
		end else if (!hold_done) begin
			hold_cnt <= hold_cnt + 1'b1;
		end
	end

	// 58 Hz frame of 256 slots
	tick_divider #(
		.DIV(PWM_SLOT_CYCLES_P)
	) slot_div (
		.clk(clk),
		.nrst(nrst),
		.tick(slot_tick)
	);

	// duty walks one step per frame toward the set point
	always_ff @(posedge clk) begin
		if (!nrst) begin
			slot_cnt <= '0;
			duty <= DUTY_RST;
		end else if (slot_tick) begin
			slot_cnt <= slot_cnt + 1'b1;
			if (slot_cnt == 8'hFF) begin
				if (vbat >= charge_setpoint && duty != 8'h00) begin
					duty <= duty - 1'b1;
				end else if (vbat < charge_setpoint && duty != 8'hFF) begin
					duty <= duty + 1'b1;
				end
			end
		end
	end

	assign pwm_high = slot_cnt < duty;

	assign battery_low = vbat < alarm_level;

	always_comb begin
		next_load = 1'b0;
		unique case (load_output_function)
			FN_SHUNT: next_load = eff_mode[1] ? !pwm_high : !slow_on;
			FN_SHUNT_INV: next_load = slow_on;
			FN_ALARM: next_load = battery_low;
			FN_ALARM_INV: next_load = !battery_low;
			default: next_load = 1'b0;
		endcase
	end

	always_comb begin
		next_relay = 1'b0;
		unique case (relay_output_function)
			FN_SHUNT: next_relay = !slow_on;
			FN_SHUNT_INV: next_relay = slow_on;
			FN_ALARM: next_relay = battery_low;
			FN_ALARM_INV: next_relay = !battery_low;
			default: next_relay = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			solar_switch <= 1'b0;
			load_switch <= 1'b0;
			relay_switch <= 1'b0;
			alarm_led <= 1'b0;
		end else begin
			solar_switch <= eff_mode[0] ? pwm_high : slow_on;
			load_switch <= next_load;
			relay_switch <= next_relay;
			alarm_led <= battery_low;
		end
	end

	// sticky events, a new event beats a clear in the same cycle
	assign irq_set[IRQ_ALARM] = battery_low & !alarm_led;
	assign irq_set[IRQ_SWITCH] = slow_change;
	assign irq_clr = (wr_pend && bus_addr == IRQ_STATUS_OFS) ? hwdata[IRQ_W-1:0] : '0;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_status <= '0;
		end else begin
			irq_status <= irq_set | (irq_status & ~irq_clr);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence ctrl_write_locked;
		wr_pend && bus_addr == CTRL_OFS && hwdata[PROGRAM_SELECT_LSB +: 3] != USER_PROGRAM;
	endsequence

	sequence slow_flip;
		$past(nrst) && $changed(slow_on);
	endsequence

	a_mode_lock: assert property (ctrl_write_locked |=> $stable(pwm_mode))
		else $error("pwm mode changed outside the user program");

	a_fixed_mode: assert property (program_select != USER_PROGRAM |-> eff_mode == FIXED_PWM_MODE)
		else $error("fixed program did not force its mode");

	a_solar_pwm_path: assert property ($past(nrst) && $past(eff_mode[0]) |-> solar_switch == $past(pwm_high))
		else $error("solar switch not following pwm");

	a_solar_slow_path: assert property ($past(nrst) && !$past(eff_mode[0]) |-> solar_switch == $past(slow_on))
		else $error("solar switch not following slow scheme");

	a_hold_time: assert property (slow_flip |-> $past(hold_done) ##1 $stable(slow_on) [*8])
		else $error("slow switch changed before hold time");

	a_slow_turn_off: assert property (slow_on && hold_done && vbat >= charge_setpoint |=> !slow_on)
		else $error("charge not turned off at set point");

	a_hysteresis_gap_band: assert property (!slow_on && vbat >= turn_on_level |=> !slow_on)
		else $error("charge turned on inside hysteresis band");

	a_alarm_led: assert property ($past(nrst) |-> alarm_led == $past(vbat < alarm_level))
		else $error("alarm indicator does not match battery level");

	a_relay_alarm: assert property ($past(nrst) && $past(relay_output_function) == FN_ALARM
		|-> relay_switch == $past(battery_low))
		else $error("relay alarm function wrong");

	a_inverse_alarm: assert property ($past(nrst) && $past(load_output_function) == FN_ALARM_INV
		|-> load_switch == !$past(battery_low))
		else $error("inverse alarm did not shed load");

	a_load_gate: assert property ($past(nrst) && $past(load_output_function) == FN_SHUNT_INV
		|-> load_switch == $past(slow_on))
		else $error("load modulated outside shunt function");

	a_relay_static: assert property ($past(nrst) && $past(relay_output_function) == FN_SHUNT
		|-> relay_switch == !$past(slow_on))
		else $error("relay followed pwm");

endmodule // charge_switch_pwm_regulator

// ===== tb/switch_bank.sv
// far-side power switch bank: tallies switch activity for the bench
module switch_bank (
	input wire logic clk,
	input wire logic clr,
	input wire logic solar_switch,
	input wire logic load_switch,
	input wire logic relay_switch,
	output int solar_edges,
	output int load_edges,
	output int relay_edges,
	output int overlap,
	output int min_gap
);
	timeunit 1ns;
	timeprecision 1ps;
	int gap = 0;
	logic s_q = 1'b0;
	logic l_q = 1'b0;
	logic r_q = 1'b0;
	always @(posedge clk) begin
		s_q <= solar_switch;
		l_q <= load_switch;
		r_q <= relay_switch;
		if (clr) begin
			solar_edges <= 0;
			load_edges <= 0;
			relay_edges <= 0;
			overlap <= 0;
			min_gap <= 1000000;
			gap <= 0;
		end else begin
			// a load shunt switch at the same level as the charge switch, open or closed, counts as overlap
			if (solar_switch === load_switch)
				overlap <= overlap + 1;
			if (load_switch !== l_q)
				load_edges <= load_edges + 1;
			if (relay_switch !== r_q)
				relay_edges <= relay_edges + 1;
			if (solar_switch !== s_q) begin
				solar_edges <= solar_edges + 1;
				if (gap > 0 && gap < min_gap)
					min_gap <= gap;
				gap <= 1;
			end else if (gap > 0)
				gap <= gap + 1;
		end
	end
endmodule // switch_bank

// ===== tb/tb.sv
// self-checking bench for the charge switch regulator
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import regulator_pkg::*;
	localparam int SLOT = 2;
	localparam int HOLD = 20;
	localparam int FRAME = SLOT * 256;
	logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
	logic hready, hresp, solar_switch, load_switch, relay_switch, alarm_led, irq;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, d1;
	logic [15:0] vbat = 16'h0000;
	logic [15:0] setp = 16'h03E8;
	int mismatches = 0, comparisons = 0, cyc = 0, seed = 93774, t0;
	int solar_edges, load_edges, relay_edges, overlap, min_gap;

	charge_switch_pwm_regulator #(.PWM_SLOT_CYCLES_P(SLOT), .HOLD_CYCLES_P(HOLD)) dut (
		.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .vbat(vbat),
		.charge_setpoint(setp), .solar_switch(solar_switch), .load_switch(load_switch),
		.relay_switch(relay_switch), .alarm_led(alarm_led), .irq(irq));
	switch_bank far_side (.clk(clk), .clr(clr), .solar_switch(solar_switch),
		.load_switch(load_switch), .relay_switch(relay_switch), .solar_edges(solar_edges),
		.load_edges(load_edges), .relay_edges(relay_edges), .overlap(overlap),
		.min_gap(min_gap));

	always #2 clk = ~clk;
	// hang guard, well above the run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one single word transfer; read data lands in rd
	task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic wait_sw(logic v);
		for (int n = 0; n < 200 && solar_switch !== v; n++) @(posedge clk);
	endtask
	task automatic pulse_clr();
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	function automatic int sat(int v);
		return (v > 255) ? 255 : v;
	endfunction
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		bus(1'b0, CTRL_OFS, 32'h0);
		check("ctrl_rst", rd, 32'h11);
		check("hresp_okay", 32'(hresp), 32'h0);
		bus(1'b0, HYSTERESIS_GAP_OFS, 32'h0);
		check("hysteresis_gap_rst", rd, 32'h100);
		bus(1'b0, IRQ_MASK_OFS, 32'h0);
		check("mask_rst", rd, 32'h0);
		bus(1'b0, 8'h1C, 32'h0);
		check("unmapped", rd, 32'h0);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, CTRL_OFS, 32'(m * 16 + 4));
			bus(1'b0, STATUS_OFS, 32'h0);
			check("eff_mode", 32'(rd[3:2]), 32'(m));
		end
		// mode field must not move outside the user program
		bus(1'b1, CTRL_OFS, 32'h01);
		bus(1'b0, CTRL_OFS, 32'h0);
		check("mode_locked", rd, 32'h31);
		bus(1'b0, STATUS_OFS, 32'h0);
		check("fixed_mode", 32'(rd[3:2]), 32'h1);
		$display("test modes done");
		// shunt load never at the same level as the solar pwm here
		bus(1'b1, FUNC_OFS, 32'h0A);
		bus(1'b1, CTRL_OFS, 32'h34);
		vbat <= 16'h01F4;
		repeat (4) @(posedge clk);
		pulse_clr();
		repeat (2 * FRAME) @(posedge clk);
		check("pwm_overlap", 32'(overlap), 32'h0);
		check("pwm_active", 32'(solar_edges > 2), 32'h1);
		check("load_pwm", 32'(load_edges > 2), 32'h1);
		check("relay_static", 32'(relay_edges), 32'h0);
		t0 = cyc;
		bus(1'b0, STATUS_OFS, 32'h0);
		d1 = rd;
		while (cyc < t0 + 10 * FRAME) @(posedge clk);
		bus(1'b0, STATUS_OFS, 32'h0);
		check("duty_rate", 32'(rd[15:8]), 32'(sat(int'(d1[15:8]) + 10)));
		bus(1'b1, FUNC_OFS, 32'h09);
		// let the new function reach the pin before the tally restarts
		repeat (2) @(posedge clk);
		pulse_clr();
		repeat (FRAME) @(posedge clk);
		check("load_unmod", 32'(load_edges), 32'h0);
		$display("test pwm done");
		bus(1'b1, FUNC_OFS, 32'h809);
		bus(1'b1, ALARM_OFS, 32'h3E8);
		for (int i = 0; i < 10; i++) begin
			vbat <= 16'($unsigned($random(seed)) % 2000);
			repeat (3) @(posedge clk);
			check("alarm_led", 32'(alarm_led), 32'(vbat < 16'h03E8));
			check("relay_alarm", 32'(relay_switch), 32'(vbat < 16'h03E8));
			check("load_inv", 32'(load_switch), 32'(vbat >= 16'h03E8));
		end
		vbat <= 16'h04B0;
		bus(1'b1, IRQ_MASK_OFS, 32'h1);
		bus(1'b1, IRQ_STATUS_OFS, 32'h3);
		vbat <= 16'h0384;
		repeat (3) @(posedge clk);
		check("irq_on", 32'(irq), 32'h1);
		bus(1'b0, IRQ_STATUS_OFS, 32'h0);
		check("irq_sts", 32'(rd[0]), 32'h1);
		bus(1'b1, IRQ_MASK_OFS, 32'h0);
		repeat (2) @(posedge clk);
		check("irq_masked", 32'(irq), 32'h0);
		bus(1'b1, IRQ_MASK_OFS, 32'h1);
		bus(1'b1, IRQ_STATUS_OFS, 32'h3);
		repeat (2) @(posedge clk);
		check("irq_clear", 32'(irq), 32'h0);
		$display("test alarm done");
		bus(1'b1, FUNC_OFS, 32'h0A);
		bus(1'b1, ALARM_OFS, 32'h0);
		bus(1'b1, CTRL_OFS, 32'h04);
		vbat <= 16'h02BC;
		// solar pin still shows the pwm level for one more edge
		repeat (2) @(posedge clk);
		wait_sw(1'b1);
		repeat (2) @(posedge clk);
		check("slow_on", 32'(solar_switch), 32'h1);
		check("shunt_slow", 32'(load_switch), 32'h0);
		pulse_clr();
		vbat <= 16'h0384;
		repeat (3 * HOLD) @(posedge clk);
		check("in_band_on", 32'(solar_switch), 32'h1);
		vbat <= 16'h03E8;
		wait_sw(1'b0);
		repeat (2) @(posedge clk);
		check("slow_off", 32'(solar_switch), 32'h0);
		check("shunt_on", 32'(load_switch), 32'h1);
		vbat <= 16'h0320;
		repeat (3 * HOLD) @(posedge clk);
		check("in_band_off", 32'(solar_switch), 32'h0);
		vbat <= 16'h02BC;
		wait_sw(1'b1);
		vbat <= 16'h03E8;
		wait_sw(1'b0);
		repeat (2) @(posedge clk);
		check("hold_gap", 32'(min_gap >= HOLD && solar_edges == 3), 32'h1);
		bus(1'b1, FUNC_OFS, 32'hA0B);
		repeat (2) @(posedge clk);
		check("inv_shunt", 32'(load_switch), 32'h0);
		check("relay_shunt", 32'(relay_switch), 32'h1);
		bus(1'b1, ALARM_OFS, 32'h3E8);
		bus(1'b1, FUNC_OFS, 32'h908);
		vbat <= 16'h0384;
		repeat (3) @(posedge clk);
		check("load_alarm", 32'(load_switch), 32'h1);
		check("relay_inv_alarm", 32'(relay_switch), 32'h0);
		$display("test slow done");
		summarize();
	end
endmodule // tb
